// [irq_unit_pkg.sv]
// Constants shared by the interrupt status and enable unit
package irq_unit_pkg;

    // Register addresses on the register port
    localparam logic [7:0] ADDR_FLAGS_A   = 8'h06;
    localparam logic [7:0] ADDR_FLAGS_B   = 8'h07;
    localparam logic [7:0] ADDR_ENABLES_A = 8'h08;
    localparam logic [7:0] ADDR_ENABLES_B = 8'h09;

    // Field layout
    localparam int REG_W       = 8;
    localparam int SET_SEL_BIT = 7;
    localparam int BANK_A_W    = 7;
    localparam int BANK_B_W    = 6;
    localparam int TIMER_COUNT = 5;
    localparam int ERR_COUNT   = 5;

    localparam int A_HIGH = 6;
    localparam int A_LOW  = 5;
    localparam int A_CMD  = 4;
    localparam int A_TX   = 3;
    localparam int A_RX   = 2;
    localparam int A_ERR  = 1;
    localparam int A_SOF  = 0;

    localparam int B_GLOBAL = 6;
    localparam int B_CARD   = 5;

    localparam int EN_A_INV  = 7;
    localparam int EN_B_PIN  = 6;
    localparam int EN_B_PUSH = 7;

    // Reset values
    localparam logic [BANK_A_W-1:0] FLAGS_A_RESET   = 7'h00;
    localparam logic [BANK_B_W-1:0] FLAGS_B_RESET   = 6'h00;
    localparam logic [REG_W-1:0]    ENABLES_A_RESET = 8'h00;
    localparam logic [REG_W-1:0]    ENABLES_B_RESET = 8'h00;

    // FIFO sizes and level widths
    localparam int FIFO_CNT_W = 10;
    localparam int WATER_W    = 9;
    localparam logic [10:0] FIFO_SIZE_LARGE = 11'h200;
    localparam logic [10:0] FIFO_SIZE_SMALL = 11'h0ff;
    localparam int CMD_W = 5;

endpackage

// [rise_detect.sv]
// Rising-edge detector for a vector of same-clock levels
module rise_detect #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels and their rising edges
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] prev;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev <= '0;
        else
            prev <= level;
    end

    assign rise = level & ~prev;

endmodule

// [sticky_flag_bank.sv]
// Sticky flag bank with set or clear by written mask
module sticky_flag_bank #(
    parameter int               WIDTH       = 7,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Software update
    input  wire logic             sw_write,
    input  wire logic             sw_set_mode,
    input  wire logic [WIDTH-1:0] sw_mask,
    // Hardware events
    input  wire logic [WIDTH-1:0] hw_set,
    // Flags
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] sw_value;
    logic [WIDTH-1:0] next_flags;

    // Written ones set or clear, written zeros keep
    assign sw_value = !sw_write  ? flags :
                      sw_set_mode ? (flags | sw_mask) : (flags & ~sw_mask);

    // Hardware set wins over a clear
    assign next_flags = sw_value | hw_set;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= RESET_VALUE;
        else
            flags <= next_flags;
    end

endmodule

// [irq_status_enable_unit.sv]
// Interrupt flag banks, enables, global summary and interrupt pin driver
module irq_status_enable_unit #(
    parameter logic [irq_unit_pkg::CMD_W-1:0] CMD_IDLE = 5'h00
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    // Register port
    input  wire logic [irq_unit_pkg::REG_W-1:0]      reg_addr,
    input  wire logic [irq_unit_pkg::REG_W-1:0]      reg_wdata,
    input  wire logic                                reg_write,
    input  wire logic                                reg_read,
    output logic      [irq_unit_pkg::REG_W-1:0]      reg_rdata,
    // FIFO state
    input  wire logic [irq_unit_pkg::FIFO_CNT_W-1:0] fifo_byte_count,
    input  wire logic [irq_unit_pkg::WATER_W-1:0]    water_level,
    input  wire logic                                fifo_size_small,
    // Command engine
    input  wire logic [irq_unit_pkg::CMD_W-1:0]      command_field,
    input  wire logic                                host_cmd_write,
    input  wire logic [irq_unit_pkg::CMD_W-1:0]      host_cmd_code,
    input  wire logic                                unknown_cmd_start,
    // Transceiver events
    input  wire logic                                transmit_last_bit,
    input  wire logic                                receive_end,
    input  wire logic                                sof_detect,
    input  wire logic                                subcarrier_detect,
    // Error levels
    input  wire logic                                fifo_write_error,
    input  wire logic                                fifo_overflow_error,
    input  wire logic                                protocol_error,
    input  wire logic                                empty_transmit_error,
    input  wire logic                                integrity_error,
    // Card detection and timers
    input  wire logic                                card_detected,
    input  wire logic [irq_unit_pkg::TIMER_COUNT-1:0] timer_underflow,
    // Interrupt pin
    output logic                                     irq_pin_out,
    output logic                                     irq_pin_oe,
    output logic                                     global_summary_flag
);

    localparam int AW = irq_unit_pkg::BANK_A_W;
    localparam int BW = irq_unit_pkg::BANK_B_W;
    localparam int LW = irq_unit_pkg::ERR_COUNT + 2;

    // Level at or below a water mark
    function automatic logic at_or_below(input logic [10:0] amount,
                                         input logic [10:0] mark);
        at_or_below = (amount <= mark);
    endfunction

    logic [AW-1:0]                     flags_a;
    logic [BW-1:0]                     flags_b;
    logic [irq_unit_pkg::REG_W-1:0]    enables_a;
    logic [irq_unit_pkg::REG_W-1:0]    enables_b;
    logic [irq_unit_pkg::CMD_W-1:0]    cmd_prev;
    logic                              host_idle_prev;

    // Register decode
    wire wr_flags_a   = reg_write && (reg_addr == irq_unit_pkg::ADDR_FLAGS_A);
    wire wr_flags_b   = reg_write && (reg_addr == irq_unit_pkg::ADDR_FLAGS_B);
    wire wr_enables_a = reg_write && (reg_addr == irq_unit_pkg::ADDR_ENABLES_A);
    wire wr_enables_b = reg_write && (reg_addr == irq_unit_pkg::ADDR_ENABLES_B);
    wire set_mode     = reg_wdata[irq_unit_pkg::SET_SEL_BIT];
    wire [AW-1:0] mask_a = reg_wdata[AW-1:0];
    wire [BW-1:0] mask_b = reg_wdata[BW-1:0];

    // FIFO live conditions
    wire [10:0] fifo_size   = fifo_size_small ? irq_unit_pkg::FIFO_SIZE_SMALL
                                              : irq_unit_pkg::FIFO_SIZE_LARGE;
    wire [10:0] count_ext   = {1'b0, fifo_byte_count};
    wire [10:0] water_ext   = fifo_size_small ? {3'h0, water_level[7:0]}
                                              : {2'h0, water_level};
    wire [10:0] free_space  = fifo_size - count_ext;
    wire        fifo_high_level = (count_ext <= fifo_size) && at_or_below(free_space, water_ext);
    wire        fifo_low_level  = at_or_below(count_ext, water_ext);

    // Rising edges of alerts and errors
    wire [LW-1:0] live_levels = {fifo_high_level, fifo_low_level, fifo_write_error,
                                 fifo_overflow_error, protocol_error,
                                 empty_transmit_error, integrity_error};
    wire [LW-1:0] level_rise;

    rise_detect #(
        .WIDTH (LW)
    ) u_rise (
        .clk   (clk),
        .rst_n (rst_n),
        .level (live_levels),
        .rise  (level_rise)
    );

    wire high_event = level_rise[LW-1];
    wire low_event  = level_rise[LW-2];
    wire err_event  = |level_rise[irq_unit_pkg::ERR_COUNT-1:0];

    // Host start of idle is not a self termination
    wire host_idle_now  = host_cmd_write && (host_cmd_code == CMD_IDLE);
    // Command ends by itself or unknown code reverts
    wire cmd_to_idle    = (cmd_prev != CMD_IDLE) && (command_field == CMD_IDLE);
    wire cmd_done_event = (cmd_to_idle && !host_idle_now && !host_idle_prev)
                          || unknown_cmd_start;

    wire [AW-1:0] hw_a = {high_event, low_event, cmd_done_event, transmit_last_bit,
                          receive_end, err_event, sof_detect | subcarrier_detect};
    // Card and timer events into bank B
    wire [BW-1:0] hw_b = {card_detected, timer_underflow};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_prev       <= CMD_IDLE;
            host_idle_prev <= 1'b0;
        end
        else
        begin
            cmd_prev       <= command_field;
            host_idle_prev <= host_idle_now;
        end
    end

    // Bank A with masked set or clear
    sticky_flag_bank #(
        .WIDTH       (AW),
        .RESET_VALUE (irq_unit_pkg::FLAGS_A_RESET)
    ) u_bank_a (
        .clk         (clk),
        .rst_n       (rst_n),
        .sw_write    (wr_flags_a),
        .sw_set_mode (set_mode),
        .sw_mask     (mask_a),
        .hw_set      (hw_a),
        .flags       (flags_a)
    );

    // Bank B low bits, summary bit kept apart
    sticky_flag_bank #(
        .WIDTH       (BW),
        .RESET_VALUE (irq_unit_pkg::FLAGS_B_RESET)
    ) u_bank_b (
        .clk         (clk),
        .rst_n       (rst_n),
        .sw_write    (wr_flags_b),
        .sw_set_mode (set_mode),
        .sw_mask     (mask_b),
        .hw_set      (hw_b),
        .flags       (flags_b)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enables_a <= irq_unit_pkg::ENABLES_A_RESET;
            enables_b <= irq_unit_pkg::ENABLES_B_RESET;
        end
        else
        begin
            if (wr_enables_a)
                enables_a <= reg_wdata;
            if (wr_enables_b)
                enables_b <= reg_wdata;
        end
    end

    wire enabled_a      = |(flags_a & enables_a[AW-1:0]);
    wire enabled_b      = |(flags_b & enables_b[BW-1:0]);
    wire next_global    = enabled_a || enabled_b;

    // Pin level after gating and polarity
    wire pin_level      = (global_summary_flag && enables_b[irq_unit_pkg::EN_B_PIN])
                          ^ enables_a[irq_unit_pkg::EN_A_INV];
    // Push-pull drives both levels, open-drain only pulls low
    wire push_pull      = enables_b[irq_unit_pkg::EN_B_PUSH];
    wire next_pin_out   = push_pull ? pin_level : 1'b0;
    wire next_pin_oe    = push_pull ? 1'b1 : !pin_level;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            global_summary_flag <= 1'b0;
            irq_pin_out         <= 1'b0;
            irq_pin_oe          <= 1'b0;
        end
        else
        begin
            global_summary_flag <= next_global;
            irq_pin_out         <= next_pin_out;
            irq_pin_oe          <= next_pin_oe;
        end
    end

    // Read selection, set selector reads zero
    wire [irq_unit_pkg::REG_W-1:0] read_value =
        (reg_addr == irq_unit_pkg::ADDR_FLAGS_A)   ? {1'b0, flags_a} :
        (reg_addr == irq_unit_pkg::ADDR_FLAGS_B)   ? {1'b0, global_summary_flag, flags_b} :
        (reg_addr == irq_unit_pkg::ADDR_ENABLES_A) ? enables_a :
        (reg_addr == irq_unit_pkg::ADDR_ENABLES_B) ? enables_b : 8'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= read_value;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire [AW-1:0] keep_a = ~(mask_a | hw_a);

    a_set_write_sets: assert property (
        wr_flags_a && set_mode |=> ((flags_a & $past(mask_a)) == $past(mask_a)))
        else $error("bank A set write did not set bits");

    a_clear_write_clears: assert property (
        wr_flags_a && !set_mode |=> ((flags_a & $past(mask_a & ~hw_a)) == 7'h00))
        else $error("bank A clear write did not clear bits");

    a_zero_bits_kept: assert property (
        wr_flags_a |=> ((flags_a & $past(keep_a)) == ($past(flags_a) & $past(keep_a))))
        else $error("bank A bits written zero changed");

    a_bank_b_write: assert property (
        wr_flags_b && set_mode |=> ((flags_b & $past(mask_b)) == $past(mask_b)))
        else $error("bank B set write did not set bits");

    a_read_bank_a: assert property (
        reg_read && (reg_addr == irq_unit_pkg::ADDR_FLAGS_A)
        |=> (reg_rdata == {1'b0, $past(flags_a)}))
        else $error("bank A read value wrong");

    a_high_event_held: assert property (
        high_event |=> flags_a[irq_unit_pkg::A_HIGH]
        ##1 (flags_a[irq_unit_pkg::A_HIGH] || $past(wr_flags_a)))
        else $error("high event flag not latched");

    a_host_idle_quiet: assert property (
        host_idle_now && !unknown_cmd_start && !flags_a[irq_unit_pkg::A_CMD] && !wr_flags_a
        |=> !flags_a[irq_unit_pkg::A_CMD])
        else $error("host idle start set command done");

    a_unknown_sets_done: assert property (
        unknown_cmd_start |=> flags_a[irq_unit_pkg::A_CMD])
        else $error("unknown command did not set command done");

    a_error_summary: assert property (
        (|level_rise[irq_unit_pkg::ERR_COUNT-1:0]) |=> flags_a[irq_unit_pkg::A_ERR])
        else $error("error summary flag not set");

    a_timer_flags: assert property (
        timer_underflow != 5'h00
        |=> ((flags_b[irq_unit_pkg::TIMER_COUNT-1:0] & $past(timer_underflow))
             == $past(timer_underflow)))
        else $error("timer flag not set");

    a_global_follows: assert property (
        (enabled_a || enabled_b) ##1 !(enabled_a || enabled_b) |=>
        !global_summary_flag && $past(global_summary_flag))
        else $error("global summary did not track sources");

    a_pin_push_pull: assert property (
        push_pull && $stable(push_pull) |=> irq_pin_oe && (irq_pin_out == $past(pin_level)))
        else $error("push-pull pin level wrong");

    a_pin_open_drain: assert property (
        !push_pull |=> !irq_pin_out && (irq_pin_oe == !$past(pin_level)))
        else $error("open-drain pin drive wrong");

    a_hw_beats_clear: assert property (
        wr_flags_a && !set_mode && ((hw_a & mask_a) != 7'h00)
        |=> ((flags_a & $past(hw_a & mask_a)) == $past(hw_a & mask_a)))
        else $error("clear beat a hardware event");

    a_bank_b_clear: assert property (
        wr_flags_b && !set_mode |=> ((flags_b & $past(mask_b & ~hw_b)) == 6'h00))
        else $error("bank B clear write did not clear bits");

    a_low_event_held: assert property (
        low_event |=> flags_a[irq_unit_pkg::A_LOW])
        else $error("low event flag not latched");

    a_cmd_self_done: assert property (
        $past(rst_n) && ($past(command_field) != CMD_IDLE) && (command_field == CMD_IDLE)
        && !host_cmd_write && !$past(host_cmd_write) |=> flags_a[irq_unit_pkg::A_CMD])
        else $error("self ended command did not set command done");

    a_transmit_done: assert property (
        transmit_last_bit |=> flags_a[irq_unit_pkg::A_TX])
        else $error("transmit done flag not set");

    a_receive_done: assert property (
        receive_end |=> flags_a[irq_unit_pkg::A_RX])
        else $error("receive done flag not set");

    a_frame_start: assert property (
        sof_detect || subcarrier_detect |=> flags_a[irq_unit_pkg::A_SOF])
        else $error("frame start flag not set");

    a_card_detect: assert property (
        card_detected |=> flags_b[irq_unit_pkg::B_CARD])
        else $error("card detect flag not set");

    a_global_from_a: assert property (
        transmit_last_bit && enables_a[irq_unit_pkg::A_TX] ##1 enables_a[irq_unit_pkg::A_TX]
        |=> global_summary_flag)
        else $error("enabled bank A source missed the summary");

    a_global_from_b: assert property (
        timer_underflow[0] && enables_b[0] ##1 enables_b[0] |=> global_summary_flag)
        else $error("enabled timer source missed the summary");

    a_pin_invert: assert property (
        push_pull && !enables_b[irq_unit_pkg::EN_B_PIN]
        |=> irq_pin_out == $past(enables_a[irq_unit_pkg::EN_A_INV]))
        else $error("pin level ignores enable or inversion");

    c_set_write:   cover property (wr_flags_a && set_mode);
    c_clash:       cover property (wr_flags_a && !set_mode && ((hw_a & mask_a) != 7'h00));
    c_pin_active:  cover property (global_summary_flag && enables_b[irq_unit_pkg::EN_B_PIN]);
    c_cmd_done:    cover property (cmd_to_idle && !host_idle_now);

endmodule

// [host_reg_model.sv]
// Host register port model issuing single-byte reads and writes
module host_reg_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end

    // One write strobe, taken at the next edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read data is loaded at the edge that takes the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// [irq_status_enable_unit_bench.sv]
// Self-checking bench for the interrupt status and enable unit
module irq_status_enable_unit_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata;
    logic [9:0]  fifo_byte_count;
    logic [8:0]  water_level;
    logic        fifo_size_small;
    logic [4:0]  command_field;
    logic        host_cmd_write;
    logic [4:0]  host_cmd_code;
    logic [15:0] ev;
    logic        irq_pin_out;
    logic        irq_pin_oe;
    logic        global_summary_flag;
    logic [7:0]  rd;
    logic [8:0]  tg;
    int          num_errors;
    int          checks_done;

    host_reg_model i_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
    );

    irq_status_enable_unit i_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .fifo_byte_count(fifo_byte_count), .water_level(water_level),
        .fifo_size_small(fifo_size_small), .command_field(command_field),
        .host_cmd_write(host_cmd_write), .host_cmd_code(host_cmd_code),
        .unknown_cmd_start(ev[9]), .transmit_last_bit(ev[0]), .receive_end(ev[1]),
        .sof_detect(ev[2]), .subcarrier_detect(ev[3]), .fifo_write_error(ev[4]),
        .fifo_overflow_error(ev[5]), .protocol_error(ev[6]),
        .empty_transmit_error(ev[7]), .integrity_error(ev[8]),
        .card_detected(ev[10]), .timer_underflow(ev[15:11]),
        .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
        .global_summary_flag(global_summary_flag)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        i_host.read_reg(a, rd);
        check(rd, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
    endtask

    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 16'h0000;
        tick(2);
    endtask

    task automatic clear_flags();
        wr(8'h06, 8'h7f);
        wr(8'h07, 8'h7f);
    endtask

    task automatic pins(input logic [7:0] exp);
        check({6'h00, irq_pin_out, irq_pin_oe}, exp);
    endtask

    // Flag bank and bit that each event input reaches
    function automatic logic [8:0] target(input int i);
        case (i)
            0:       return 9'h008;
            1:       return 9'h004;
            2, 3:    return 9'h001;
            9:       return 9'h010;
            10:      return 9'h120;
            default: return (i < 9) ? 9'h002 : {1'b1, 8'h01 << (i - 11)};
        endcase
    endfunction

    initial
    begin
        #100000;
        num_errors++;
        $display("Watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        rst_n = 1'b0;
        fifo_byte_count = 10'h000;
        water_level = 9'h000;
        fifo_size_small = 1'b0;
        command_field = 5'h00;
        host_cmd_write = 1'b0;
        host_cmd_code = 5'h00;
        ev = 16'h0000;
        num_errors = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_check(8'h06, 8'h20);
        rd_check(8'h07, 8'h00);
        rd_check(8'h08, 8'h00);
        rd_check(8'h09, 8'h00);
        rd_check(8'h0a, 8'h00);
        $display("Test reset done");
        wr(8'h06, 8'hff);
        rd_check(8'h06, 8'h7f);
        wr(8'h06, 8'h7f);
        rd_check(8'h06, 8'h00);
        wr(8'h06, 8'h81);
        wr(8'h06, 8'h82);
        rd_check(8'h06, 8'h03);
        wr(8'h06, 8'h01);
        rd_check(8'h06, 8'h02);
        wr(8'h07, 8'hff);
        rd_check(8'h07, 8'h3f);
        wr(8'h07, 8'h7f);
        rd_check(8'h07, 8'h00);
        wr(8'h08, 8'ha5);
        rd_check(8'h08, 8'ha5);
        wr(8'h08, 8'h00);
        $display("Test set_clear done");
        for (int i = 0; i < 16; i++)
        begin
            clear_flags();
            pulse(16'h0001 << i);
            tg = target(i);
            rd_check(tg[8] ? 8'h07 : 8'h06, tg[7:0]);
        end
        clear_flags();
        fork
            wr(8'h06, 8'h7f);
            pulse(16'h0001);
        join
        rd_check(8'h06, 8'h08);
        $display("Test events done");
        clear_flags();
        @(posedge clk);
        water_level <= 9'h010;
        fifo_byte_count <= 10'h1f8;
        tick(3);
        rd_check(8'h06, 8'h40);
        @(posedge clk);
        fifo_byte_count <= 10'h005;
        tick(3);
        rd_check(8'h06, 8'h60);
        clear_flags();
        @(posedge clk);
        fifo_byte_count <= 10'h0f5;
        tick(3);
        @(posedge clk);
        fifo_size_small <= 1'b1;
        water_level <= 9'h110;
        tick(3);
        rd_check(8'h06, 8'h40);
        $display("Test fifo done");
        clear_flags();
        @(posedge clk);
        command_field <= 5'h03;
        tick(2);
        @(posedge clk);
        command_field <= 5'h00;
        tick(3);
        rd_check(8'h06, 8'h10);
        clear_flags();
        @(posedge clk);
        command_field <= 5'h03;
        tick(2);
        @(posedge clk);
        command_field <= 5'h00;
        host_cmd_write <= 1'b1;
        host_cmd_code <= 5'h00;
        @(posedge clk);
        host_cmd_write <= 1'b0;
        tick(3);
        rd_check(8'h06, 8'h00);
        $display("Test command done");
        clear_flags();
        wr(8'h08, 8'h08);
        wr(8'h09, 8'h41);
        pulse(16'h0001);
        tick(2);
        check({7'h00, global_summary_flag}, 8'h01);
        pins(8'h00);
        rd_check(8'h07, 8'h40);
        wr(8'h09, 8'hc1);
        tick(2);
        pins(8'h03);
        wr(8'h08, 8'h88);
        tick(2);
        pins(8'h01);
        wr(8'h09, 8'h80);
        tick(2);
        pins(8'h03);
        wr(8'h08, 8'h00);
        wr(8'h09, 8'hc1);
        wr(8'h06, 8'h7f);
        tick(3);
        check({7'h00, global_summary_flag}, 8'h00);
        pins(8'h01);
        pulse(16'h0800);
        tick(2);
        check({7'h00, global_summary_flag}, 8'h01);
        pins(8'h03);
        $display("Test pin done");
        tally_and_finish();
    end
endmodule
